// *** pmc_power_mode_controller.v ***
`include "pmc_regs.vh"
`default_nettype none
module pmc_power_mode_controller #(
  parameter IO_W = 8,
  parameter SEQ_W = 8
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_por,
  input wire i_mode_wr,
  input wire [1:0] i_mode_wdata,
  input wire i_idle_wr,
  input wire i_idle_wdata,
  input wire i_src_wr,
  input wire i_src_wdata,
  input wire i_lssel_wr,
  input wire i_lssel_wdata,
  input wire i_irq_any,
  input wire i_port_irq,
  input wire i_sleep_timer_irq,
  input wire i_crystal_ready,
  input wire i_fast_rc_ready,
  input wire [IO_W-1:0] i_io_dir,
  input wire [IO_W-1:0] i_io_out,
  output reg [1:0] o_mode_select,
  output wire o_power_idle_trigger,
  output reg o_sysclk_source_select,
  output reg o_low_speed_osc_select,
  output wire o_crystal_stable_flag,
  output wire o_fast_rc_stable_flag,
  output reg o_cpu_clk_en,
  output reg o_periph_clk_en,
  output reg o_regulator_en,
  output reg o_crystal_oscillator_en,
  output reg o_fast_rc_oscillator_en,
  output reg o_low_power_rc_oscillator_en,
  output reg o_crystal32k_en,
  output reg o_sysclk_use_fast_rc,
  output reg o_usb_reset,
  output reg o_io_hold,
  output reg [IO_W-1:0] o_io_dir,
  output reg [IO_W-1:0] o_io_out,
  output wire o_port_irq_unblocked,
  output wire o_sleep_irq_unblocked,
  output reg o_restart,
  output reg [2:0] o_state
);
  // ----------------------------------------
  // states and sequence lengths
  // ----------------------------------------
  localparam [2:0] ST_ACTIVE = 3'h0;
  localparam [2:0] ST_CPU_IDLE = 3'h1;
  localparam [2:0] ST_PWR_DOWN = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_PWR_UP = 3'h4;
  localparam [2:0] ST_XTAL_WAIT = 3'h5;
  localparam integer FAST_CYC =
    (`PMC_FAST_SEQ_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;
  localparam integer SLOW_CYC =
    (`PMC_SLOW_SEQ_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;
  localparam [SEQ_W-1:0] FAST_CNT = FAST_CYC[SEQ_W-1:0];
  localparam [SEQ_W-1:0] SLOW_CNT = SLOW_CYC[SEQ_W-1:0];

  // ----------------------------------------
  // synchronised pin inputs
  // ----------------------------------------
  wire [3:0] sync_out;
  wire por_s;
  wire port_s;
  wire xtal_s;
  wire hfrc_s;
  pmc_sync #(.W(4)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_por, i_port_irq, i_crystal_ready, i_fast_rc_ready}),
    .o_sync(sync_out)
  );
  assign por_s = sync_out[3];
  assign port_s = sync_out[2];
  assign xtal_s = sync_out[1];
  assign hfrc_s = sync_out[0];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] sleep_mode_reg;
  reg xtal_was_on_reg;
  reg hfrc_was_on_reg;
  reg seq_start;
  reg [SEQ_W-1:0] seq_count;
  wire seq_done;

  pmc_seq_timer #(.W(SEQ_W)) u_seq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(seq_start),
    .i_count(seq_count),
    .o_done(seq_done)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function is_slow_mode;
    input [1:0] m;
    begin
      is_slow_mode = (m == `PMC_MODE_TIMER) || (m == `PMC_MODE_DEEP);
    end
  endfunction

  // wake sources while asleep
  wire timer_wake = i_sleep_timer_irq &&
    (sleep_mode_reg != `PMC_MODE_DEEP);
  wire sleep_wake = port_s || timer_wake;
  wire mode_zero = (o_mode_select == `PMC_MODE_IDLE);
  wire do_enter = i_idle_wr && i_idle_wdata && (state_reg == ST_ACTIVE);

  assign o_power_idle_trigger = 1'b0;
  assign o_crystal_stable_flag = xtal_s;
  assign o_fast_rc_stable_flag = hfrc_s;
  assign o_port_irq_unblocked = mode_zero;
  assign o_sleep_irq_unblocked = mode_zero;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    seq_start = 1'b0;
    seq_count = FAST_CNT;
    case (state_reg)
      ST_ACTIVE: begin
        if (do_enter) begin
          if (mode_zero) begin
            state_next = ST_CPU_IDLE;
          end else begin
            state_next = ST_PWR_DOWN;
            seq_start = 1'b1;
            seq_count = is_slow_mode(o_mode_select) ?
              SLOW_CNT : FAST_CNT;
          end
        end
      end
      ST_CPU_IDLE: begin
        if (i_irq_any) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_PWR_DOWN: begin
        if (seq_done) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          state_next = ST_PWR_UP;
          seq_start = 1'b1;
          seq_count = is_slow_mode(sleep_mode_reg) ?
            SLOW_CNT : FAST_CNT;
        end
      end
      ST_PWR_UP: begin
        if (seq_done) begin
          state_next = ST_XTAL_WAIT;
        end
      end
      ST_XTAL_WAIT: begin
        if (!xtal_was_on_reg || xtal_s) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  // ----------------------------------------
  // state and control bits
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst || por_s) begin
      state_reg <= ST_ACTIVE;
      o_mode_select <= `PMC_MODE_RST;
      sleep_mode_reg <= `PMC_MODE_RST;
      o_sysclk_source_select <= `PMC_SRC_RST;
      o_low_speed_osc_select <= `PMC_LSSEL_RST;
      xtal_was_on_reg <= 1'b0;
      hfrc_was_on_reg <= 1'b1;
      o_restart <= 1'b1;
    end else begin
      state_reg <= state_next;
      o_restart <= 1'b0;
      if (i_src_wr) begin
        o_sysclk_source_select <= i_src_wdata;
      end
      if (i_lssel_wr) begin
        o_low_speed_osc_select <= i_lssel_wdata;
      end
      if (state_reg == ST_ACTIVE && state_next == ST_PWR_DOWN) begin
        sleep_mode_reg <= o_mode_select;
        xtal_was_on_reg <= o_crystal_oscillator_en;
        hfrc_was_on_reg <= o_fast_rc_oscillator_en;
      end
      // hardware clear on entry or wake beats software write
      if (state_next == ST_SLEEP && state_reg == ST_PWR_DOWN) begin
        o_mode_select <= `PMC_MODE_IDLE;
      end else if (state_reg == ST_SLEEP && sleep_wake) begin
        o_mode_select <= `PMC_MODE_IDLE;
      end else if (i_mode_wr) begin
        o_mode_select <= i_mode_wdata;
      end
    end
  end

  // ----------------------------------------
  // power, clock and pin outputs
  // ----------------------------------------
  wire in_low = (state_reg == ST_PWR_DOWN) || (state_reg == ST_SLEEP) ||
    (state_reg == ST_PWR_UP);
  wire slow_now = is_slow_mode(sleep_mode_reg);
  // por drops straight back to active, like the state register
  wire [2:0] state_go = por_s ? ST_ACTIVE : state_next;
  wire go_sleep = (state_go == ST_SLEEP);
  wire leave_sleep = (state_reg == ST_SLEEP) && !go_sleep;

  function hs_fallback;
    input src_rc;
    input xtal_ok;
    begin
      hs_fallback = src_rc || !xtal_ok;
    end
  endfunction

  // ----------------------------------------
  // clock gates and regulator
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_state <= ST_ACTIVE;
      o_cpu_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_regulator_en <= 1'b1;
      o_usb_reset <= 1'b0;
    end else begin
      o_state <= state_go;
      o_cpu_clk_en <= (state_go == ST_ACTIVE) ||
        (state_go == ST_XTAL_WAIT);
      o_periph_clk_en <= !go_sleep;
      o_regulator_en <= !(go_sleep && slow_now);
      o_usb_reset <= go_sleep && slow_now;
    end
  end

  // ----------------------------------------
  // high-speed oscillators
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_crystal_oscillator_en <= 1'b0;
      o_fast_rc_oscillator_en <= 1'b1;
      o_sysclk_use_fast_rc <= 1'b1;
    end else begin
      if (go_sleep) begin
        o_crystal_oscillator_en <= 1'b0;
        o_fast_rc_oscillator_en <= 1'b0;
      end else if (leave_sleep) begin
        // fast rc is the fallback clock while crystal starts
        o_crystal_oscillator_en <= xtal_was_on_reg;
        o_fast_rc_oscillator_en <= hfrc_was_on_reg || xtal_was_on_reg;
      end else if (state_reg == ST_ACTIVE) begin
        o_crystal_oscillator_en <= !o_sysclk_source_select ||
          o_crystal_oscillator_en;
        o_fast_rc_oscillator_en <=
          hs_fallback(o_sysclk_source_select, xtal_s);
      end
      o_sysclk_use_fast_rc <=
        hs_fallback(o_sysclk_source_select, xtal_s);
    end
  end

  // ----------------------------------------
  // low-speed oscillator, off only in deepest sleep
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_low_power_rc_oscillator_en <= 1'b1;
      o_crystal32k_en <= 1'b0;
    end else if (go_sleep && sleep_mode_reg == `PMC_MODE_DEEP) begin
      o_low_power_rc_oscillator_en <= 1'b0;
      o_crystal32k_en <= 1'b0;
    end else begin
      o_low_power_rc_oscillator_en <= o_low_speed_osc_select;
      o_crystal32k_en <= !o_low_speed_osc_select;
    end
  end

  // ----------------------------------------
  // pin hold
  // ----------------------------------------
  // pins captured up to one cycle before power down starts, not in the trigger cycle
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_io_hold <= 1'b0;
      o_io_dir <= {IO_W{1'b0}};
      o_io_out <= {IO_W{1'b0}};
    end else begin
      o_io_hold <= in_low;
      if (!in_low && state_go != ST_PWR_DOWN) begin
        o_io_dir <= i_io_dir;
        o_io_out <= i_io_out;
      end
    end
  end
endmodule
`default_nettype wire

// *** pmc_regs.vh ***
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// mode select encodings
`define PMC_MODE_IDLE 2'h0
`define PMC_MODE_FAST 2'h1
`define PMC_MODE_TIMER 2'h2
`define PMC_MODE_DEEP 2'h3
// reset values
`define PMC_MODE_RST 2'h0
`define PMC_SRC_RST 1'h1
`define PMC_LSSEL_RST 1'h1
// sequence timing, ns
`define PMC_CLK_NS 20
`define PMC_FAST_SEQ_NS 200
`define PMC_SLOW_SEQ_NS 2000
`endif

// *** pmc_sync.v ***
`default_nettype none
module pmc_sync #(
  parameter W = 1
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  // ----------------------------------------
  // three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_sync <= (s2_reg & s3_reg) | (o_sync & (s2_reg | s3_reg));
    end
  end
endmodule
`default_nettype wire

// *** pmc_seq_timer.v ***
`default_nettype none
module pmc_seq_timer #(
  parameter W = 8
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_start,
  input wire [W-1:0] i_count,
  output wire o_done
);
  reg [W-1:0] cnt_reg;
  reg run_reg;
  // ----------------------------------------
  // one-shot countdown
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= i_count;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg == {W{1'b0}}) begin
        run_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
  assign o_done = run_reg && (cnt_reg == {W{1'b0}});
endmodule
`default_nettype wire

// *** pmc_properties.sv ***
`default_nettype none
// ----------------------------------------
// mode sequencing checks
// ----------------------------------------
module pmc_properties #(
  parameter int IO_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_idle_wr,
  input wire logic i_idle_wdata,
  input wire logic i_irq_any,
  input wire logic [1:0] o_mode_select,
  input wire logic o_power_idle_trigger,
  input wire logic o_crystal_oscillator_en,
  input wire logic o_fast_rc_oscillator_en,
  input wire logic o_cpu_clk_en,
  input wire logic o_io_hold,
  input wire logic [IO_W-1:0] o_io_dir,
  input wire logic [IO_W-1:0] o_io_out,
  input wire logic o_port_irq_unblocked,
  input wire logic o_sleep_irq_unblocked,
  input wire logic o_restart,
  input wire logic [2:0] o_state
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  idle_reads_zero_a: assert property (!o_power_idle_trigger)
    else $error("idle trigger read nonzero");
  irq_block_a: assert property (
    o_port_irq_unblocked == (o_mode_select == 2'h0) &&
    o_sleep_irq_unblocked == (o_mode_select == 2'h0))
    else $error("wake irq gating wrong");
  idle_gate_a: assert property (
    o_state == 3'h0 && i_idle_wr && i_idle_wdata && o_mode_select == 2'h0
    |-> ##[1:2] o_state == 3'h1 && !o_cpu_clk_en)
    else $error("cpu clock not gated");
  idle_wake_a: assert property (
    o_state == 3'h1 && i_irq_any |-> ##[1:2] o_state == 3'h0)
    else $error("no wake from cpu idle");
  fast_entry_a: assert property (
    o_state == 3'h0 && i_idle_wr && i_idle_wdata && o_mode_select == 2'h1
    |-> ##2 (o_state == 3'h2) [*7] ##[1:6] o_state == 3'h3)
    else $error("fast power down timing");
  slow_entry_a: assert property (
    o_state == 3'h0 && i_idle_wr && i_idle_wdata && o_mode_select[1]
    |-> ##2 (o_state == 3'h2) [*7] ##[90:100] o_state == 3'h3)
    else $error("slow power down timing");
  mode_clear_a: assert property (
    o_state == 3'h3 |-> o_mode_select == 2'h0)
    else $error("mode select not cleared");
  sleep_osc_off_a: assert property (
    o_state == 3'h3 |-> !o_crystal_oscillator_en && !o_fast_rc_oscillator_en)
    else $error("fast oscillator on in sleep");
  pin_hold_a: assert property (
    o_io_hold && $past(o_io_hold) |-> $stable(o_io_dir) && $stable(o_io_out))
    else $error("io pins moved while held");
  restart_a: assert property ($fell(i_rst) |-> o_restart)
    else $error("no restart after reset");
endmodule
`default_nettype wire

// *** test_pmc_power_mode_controller.sv ***
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module test_pmc_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IO_W = 8;
  logic i_core_clk = 0, i_rst = 1, i_por = 0;
  logic i_mode_wr = 0, i_idle_wr = 0, i_idle_wdata = 0;
  logic [1:0] i_mode_wdata = 0;
  logic i_src_wr = 0, i_src_wdata = 0, i_lssel_wr = 0, i_lssel_wdata = 0;
  logic i_irq_any = 0, i_port_irq = 0, i_sleep_timer_irq = 0;
  logic i_crystal_ready = 1, i_fast_rc_ready = 1;
  logic [IO_W-1:0] i_io_dir = 0, i_io_out = 0, o_io_dir, o_io_out;
  logic [IO_W-1:0] dir_s, out_s;
  logic [1:0] o_mode_select;
  logic [2:0] o_state;
  logic o_power_idle_trigger, o_sysclk_source_select, o_low_speed_osc_select;
  logic o_crystal_stable_flag, o_fast_rc_stable_flag, o_cpu_clk_en;
  logic o_periph_clk_en, o_regulator_en, o_crystal_oscillator_en;
  logic o_fast_rc_oscillator_en, o_low_power_rc_oscillator_en;
  logic o_crystal32k_en, o_sysclk_use_fast_rc, o_usb_reset, o_io_hold;
  logic o_port_irq_unblocked, o_sleep_irq_unblocked, o_restart;
  integer seed = 17, n_mismatch = 0, checked = 0, k, m;

  pmc_power_mode_controller #(.IO_W(IO_W)) dut_u (.*);

  initial forever #10 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic wait_st(input logic [2:0] s);
    int i = 0;
    while (o_state !== s && i < 300) begin
      tick(1);
      i++;
    end
    if (o_state !== s) begin
      n_mismatch++;
      $display("CHECK FAILED %0t wait timeout", $time);
      close_out();
    end
  endtask

  task automatic wr_mode(input logic [1:0] v);
    i_mode_wr = 1;
    i_mode_wdata = v;
    tick(1);
    i_mode_wr = 0;
  endtask

  task automatic trig;
    i_idle_wr = 1;
    i_idle_wdata = 1;
    tick(1);
    i_idle_wr = 0;
  endtask

  initial begin
    tick(4);
    i_rst = 0;
    tick(5);
    chk(o_mode_select, 2'h0);
    chk(o_regulator_en, 1'h1);
    chk(o_power_idle_trigger, 1'h0);
    chk(o_fast_rc_stable_flag, 1'h1);
    for (k = 0; k < 2; k++) begin
      i_lssel_wr = 1;
      i_lssel_wdata = k[0];
      tick(1);
      i_lssel_wr = 0;
      chk(o_low_speed_osc_select, k[0]);
      chk(o_crystal32k_en ^ o_low_power_rc_oscillator_en, 1'h1);
      tick(1);
      chk(o_low_power_rc_oscillator_en, k[0]);
    end
    for (k = 0; k < 4; k++) begin
      wr_mode(k[1:0]);
      chk(o_mode_select, k[1:0]);
      chk(o_port_irq_unblocked, k == 0);
      chk(o_sleep_irq_unblocked, k == 0);
    end
    wr_mode(2'h0);
    trig();
    tick(2);
    chk(o_state, 3'h1);
    chk(o_cpu_clk_en, 1'h0);
    chk(o_periph_clk_en, 1'h1);
    i_irq_any = 1;
    tick(1);
    i_irq_any = 0;
    tick(1);
    chk(o_state, 3'h0);
    chk(o_cpu_clk_en, 1'h1);
    $display("test idle done");
    for (m = 1; m < 4; m++) begin
      i_src_wr = 1;
      tick(1);
      i_src_wr = 0;
      tick(8);
      dir_s = $random(seed);
      out_s = $random(seed);
      i_io_dir = dir_s;
      i_io_out = out_s;
      wr_mode(m[1:0]);
      tick(3);
      chk(o_mode_select, m[1:0]);
      trig();
      wait_st(3'h3);
      i_crystal_ready = 0;
      i_io_dir = ~dir_s;
      i_io_out = $random(seed);
      i_sleep_timer_irq = (m == 3);
      tick(10);
      chk(o_state, 3'h3);
      chk(o_mode_select, 2'h0);
      chk(o_port_irq_unblocked, 1'h1);
      chk(o_io_hold, 1'h1);
      chk(o_io_dir, dir_s);
      chk(o_io_out, out_s);
      chk(o_regulator_en, m == 1);
      chk(o_low_power_rc_oscillator_en, m != 3);
      chk(o_usb_reset, m != 1);
      i_port_irq = (m != 2);
      i_sleep_timer_irq = (m == 2);
      wait_st(3'h5);
      i_port_irq = 0;
      i_sleep_timer_irq = 0;
      chk(o_sysclk_use_fast_rc, 1'h1);
      chk(o_crystal_oscillator_en, 1'h1);
      chk(o_fast_rc_oscillator_en, 1'h1);
      chk(o_crystal_stable_flag, 1'h0);
      i_crystal_ready = 1;
      wait_st(3'h0);
      tick(4);
      chk(o_sysclk_use_fast_rc, 1'h0);
      chk(o_restart, 1'h0);
      chk(o_sysclk_source_select, 1'h0);
      $display("test sleep %0d done", m);
    end
    wr_mode(2'h2);
    i_por = 1;
    tick(6);
    chk(o_restart, 1'h1);
    chk(o_mode_select, 2'h0);
    chk(o_sysclk_source_select, 1'h1);
    i_por = 0;
    tick(6);
    chk(o_restart, 1'h0);
    $display("test por done");
    close_out();
  end
endmodule

bind pmc_power_mode_controller pmc_properties #(.IO_W(IO_W)) chk_u (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_idle_wr(i_idle_wr),
  .i_idle_wdata(i_idle_wdata),
  .i_irq_any(i_irq_any),
  .o_mode_select(o_mode_select),
  .o_power_idle_trigger(o_power_idle_trigger),
  .o_crystal_oscillator_en(o_crystal_oscillator_en),
  .o_fast_rc_oscillator_en(o_fast_rc_oscillator_en),
  .o_cpu_clk_en(o_cpu_clk_en),
  .o_io_hold(o_io_hold),
  .o_io_dir(o_io_dir),
  .o_io_out(o_io_out),
  .o_port_irq_unblocked(o_port_irq_unblocked),
  .o_sleep_irq_unblocked(o_sleep_irq_unblocked),
  .o_restart(o_restart),
  .o_state(o_state)
);
`default_nettype wire
